// ---- shared/bst_pkg.sv ----
// Constants and types for the boundary-scan test operations block.
// What this block does
// - Sample scans boundary register, device stays normal.
// - High-impedance floats all pins, core keeps running.
// - Bypass register captures zero at Capture-DR.
// - Clamp drives pins and core from cells.
// - Run test executes control-register operation in idle.
// - Boundary reads leave boundary register unchanged.
// - Self test captures inverse of cell values.
// - Toggle outputs inverts output cells each idle clock.
// - Control scan capture leaves control register unchanged.
// - Control bits 1..0 select the test operation; bit 2 selects counting in combined mode.
// - Control cells excluded; enable cells still gate.
// - Operations need exactly one direction enabled.
// - Control bits 10..3 mask inputs 8..1.
// - Masked input never affects the signature.
// - Sample/toggle captures inputs, toggles outputs.
// - Pattern mode steps 16-bit pseudo-random sequence.
// - All-zero seed keeps pattern generator stuck.
// - 16-bit signature compresses inputs, outputs held.
// - Combined mode: 8-bit signature plus 8-bit pattern.
// - Unsupported instruction codes act as bypass.
// - Control register is 11 bits, resets to signature.
// - Eight-bit even-parity instruction codes.
`default_nettype none
package bst_pkg;
  // Instruction codes, bit 7 keeps even parity.
  localparam logic [7:0] IR_EXTEST_A      = 8'h00;
  localparam logic [7:0] IR_SAMPLE        = 8'h82;
  localparam logic [7:0] IR_EXTEST_B      = 8'h03;
  localparam logic [7:0] IR_HIGHZ         = 8'h06;
  localparam logic [7:0] IR_CLAMP         = 8'h87;
  localparam logic [7:0] IR_RUN_TEST      = 8'h09;
  localparam logic [7:0] IR_READ_NORMAL   = 8'h0a;
  localparam logic [7:0] IR_READ_TEST     = 8'h8b;
  localparam logic [7:0] IR_CELL_SELF     = 8'h0c;
  localparam logic [7:0] IR_TOGGLE_OUT    = 8'h8d;
  localparam logic [7:0] IR_CTRL_NORMAL   = 8'h8e;
  localparam logic [7:0] IR_CTRL_TEST     = 8'h0f;
  localparam logic [7:0] IR_CAPTURE_VAL   = 8'h81;
  localparam logic [7:0] IR_RESET_VAL     = 8'h81;
  // Boundary-control register layout and reset value.
  localparam logic [10:0] BCR_RESET       = 11'h002;
  localparam int          BCR_MASK_LO     = 3;
  localparam int          BCR_COUNT_BIT   = 2;
  localparam logic [1:0]  OP_SAMPLE_TOG   = 2'h0;
  localparam logic [1:0]  OP_PATTERN      = 2'h1;
  localparam logic [1:0]  OP_SIGNATURE    = 2'h2;
  localparam logic [1:0]  OP_COMBINED     = 2'h3;
  // Boundary register layout.
  localparam int          BSR_A_TO_B_OUTPUT_ENABLE_N        = 37;
  localparam int          BSR_B_TO_A_OUTPUT_ENABLE_N        = 36;
  localparam int          BSR_CTRL_LO     = 32;
  localparam int          BSR_AI_LO       = 24;
  localparam int          BSR_AO_LO       = 16;
  localparam int          BSR_BI_LO       = 8;
  localparam int          BSR_BO_LO       = 0;
  // Feedback taps per direction.
  localparam logic [15:0] TAP16_AB        = 16'h002d;
  localparam logic [15:0] TAP16_BA        = 16'h1021;
  localparam logic [7:0]  TAP8_AB         = 8'h1d;
  localparam logic [7:0]  TAP8_BA         = 8'h2b;

  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } bst_tap_e;
endpackage : bst_pkg
`default_nettype wire

// ---- design/bst_scan_ops.sv ----
// Boundary-scan instruction and run-test operation logic of the transceiver.
`default_nettype none
module bst_scan_ops (
  input  wire logic        clock_i,
  input  wire logic        arst_n_i,
  input  wire logic        tck_i,
  input  wire logic        tms_i,
  input  wire logic        tdi_i,
  output logic             tdo_o,
  output logic             tdo_oe_o,
  input  wire logic [5:0]  ctrl_pin_i,
  input  wire logic [7:0]  a_pin_i,
  input  wire logic [7:0]  b_pin_i,
  input  wire logic [7:0]  core_a_i,
  input  wire logic [7:0]  core_b_i,
  output logic [7:0]       a_out_o,
  output logic             a_oe_o,
  output logic [7:0]       b_out_o,
  output logic             b_oe_o,
  output logic [21:0]      to_core_o
);
  import bst_pkg::*;

  typedef struct packed {
    logic [2:0]  tck_s;
    logic [1:0]  tms_s;
    logic [1:0]  tdi_s;
    logic [21:0] pin_s1;
    logic [21:0] pin_s2;
    bst_tap_e    tap;
    logic [7:0]  ir_sh;
    logic [7:0]  ir;
    logic        bypass;
    logic [37:0] boundary_register;
    logic [37:0] shadow;
    logic [10:0] boundary_control;
    logic        tdo;
    logic        tdo_oe;
    logic [7:0]  a_out;
    logic        a_oe;
    logic [7:0]  b_out;
    logic        b_oe;
    logic [21:0] to_core;
  } bst_state_s;

  bst_state_s st;
  bst_state_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Galois shift step; an all-zero value stays zero.
  function automatic logic [15:0] lfsr16(input logic [15:0] x, input logic [15:0] t);
    lfsr16 = {x[14:0], 1'b0} ^ (x[15] ? t : 16'h0000);
  endfunction : lfsr16

  function automatic logic [7:0] lfsr8(input logic [7:0] x, input logic [7:0] t);
    lfsr8 = {x[6:0], 1'b0} ^ (x[7] ? t : 8'h00);
  endfunction : lfsr8

  // TAP state sequencing on a test clock rising edge.
  function automatic bst_tap_e tap_next(input bst_tap_e s, input logic m);
    case (s)
      TAP_RESET:    tap_next = m ? TAP_RESET : TAP_IDLE;
      TAP_IDLE:     tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR:   tap_next = m ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR:   tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_SHIFT_DR: tap_next = m ? TAP_EXIT1_DR : TAP_SHIFT_DR;
      TAP_EXIT1_DR: tap_next = m ? TAP_UPD_DR : TAP_PAUSE_DR;
      TAP_PAUSE_DR: tap_next = m ? TAP_EXIT2_DR : TAP_PAUSE_DR;
      TAP_EXIT2_DR: tap_next = m ? TAP_UPD_DR : TAP_SHIFT_DR;
      TAP_UPD_DR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR:   tap_next = m ? TAP_RESET : TAP_CAP_IR;
      TAP_CAP_IR:   tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_SHIFT_IR: tap_next = m ? TAP_EXIT1_IR : TAP_SHIFT_IR;
      TAP_EXIT1_IR: tap_next = m ? TAP_UPD_IR : TAP_PAUSE_IR;
      TAP_PAUSE_IR: tap_next = m ? TAP_EXIT2_IR : TAP_PAUSE_IR;
      TAP_EXIT2_IR: tap_next = m ? TAP_UPD_IR : TAP_SHIFT_IR;
      TAP_UPD_IR:   tap_next = m ? TAP_SEL_DR : TAP_IDLE;
      default:      tap_next = TAP_RESET;
    endcase
  endfunction : tap_next

  ////////////////////////////////////////////////////////////////////////////
  // Decode.

  logic        tck_rise;
  logic        tck_fall;
  logic        tms;
  logic        tdi;
  logic [21:0] pins;
  logic        sel_bsr;
  logic        sel_bcr;
  logic        test_mode;
  logic        is_read;
  logic        one_dir;
  logic        a_to_b;
  logic        run_step;
  logic [7:0]  in_pins;
  logic [7:0]  mask;
  logic [7:0]  cur_in;
  logic [7:0]  cur_out;
  logic [7:0]  new_in;
  logic [7:0]  new_out;
  logic [15:0] tap16;
  logic [7:0]  tap8;

  // Edges of the synchronised test clock and synchronised pins.
  assign tck_rise = st.tck_s[1] & ~st.tck_s[2];
  assign tck_fall = ~st.tck_s[1] & st.tck_s[2];
  assign tms      = st.tms_s[1];
  assign tdi      = st.tdi_s[1];
  assign pins     = st.pin_s2;

  // Data register selection; any other code falls to bypass.
  assign sel_bsr = st.ir inside {IR_EXTEST_A, IR_EXTEST_B, IR_SAMPLE, IR_READ_NORMAL,
                                 IR_READ_TEST, IR_CELL_SELF};
  assign sel_bcr = st.ir inside {IR_CTRL_NORMAL, IR_CTRL_TEST};
  assign is_read = st.ir inside {IR_READ_NORMAL, IR_READ_TEST};
  assign test_mode = st.ir inside {IR_EXTEST_A, IR_EXTEST_B, IR_CLAMP, IR_RUN_TEST,
                                   IR_READ_TEST, IR_TOGGLE_OUT, IR_CTRL_TEST};

  // Direction from the two output-enable cells, active low.
  assign one_dir = st.shadow[BSR_A_TO_B_OUTPUT_ENABLE_N] ^ st.shadow[BSR_B_TO_A_OUTPUT_ENABLE_N];
  assign a_to_b  = ~st.shadow[BSR_A_TO_B_OUTPUT_ENABLE_N];
  assign run_step = tck_rise && st.tap == TAP_IDLE && one_dir &&
                    (st.ir == IR_RUN_TEST || st.ir == IR_TOGGLE_OUT);

  // Selected cells exclude the control cells.
  assign in_pins = a_to_b ? pins[15:8] : pins[7:0];
  assign cur_in  = a_to_b ? st.boundary_register[BSR_AI_LO +: 8] : st.boundary_register[BSR_BI_LO +: 8];
  assign cur_out = a_to_b ? st.boundary_register[BSR_BO_LO +: 8] : st.boundary_register[BSR_AO_LO +: 8];
  assign mask    = st.boundary_control[BCR_MASK_LO +: 8];
  assign tap16   = a_to_b ? TAP16_AB : TAP16_BA;
  assign tap8    = a_to_b ? TAP8_AB : TAP8_BA;

  // One step of the selected operation on the selected cells.
  always_comb begin
    new_in  = cur_in;
    new_out = ~cur_out;
    if (st.ir == IR_RUN_TEST) begin
      case (st.boundary_control[1:0])
        OP_SAMPLE_TOG: begin
          new_in  = in_pins;
          new_out = ~cur_out;
        end
        OP_PATTERN: begin
          {new_in, new_out} = lfsr16({cur_in, cur_out}, tap16);
        end
        OP_SIGNATURE: begin
          // Masked inputs are cleared before they are folded in.
          {new_in, new_out} = lfsr16({cur_in, cur_out}, tap16) ^
                              {in_pins & ~mask, 8'h00};
        end
        OP_COMBINED: begin
          new_in  = lfsr8(cur_in, tap8) ^ (in_pins & ~mask);
          new_out = st.boundary_control[BCR_COUNT_BIT] ? cur_out + 8'h01 : lfsr8(cur_out, tap8);
        end
        default: begin
          new_in  = cur_in;
          new_out = cur_out;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State update.

  // Fills the next state from test clock edges and decoded instruction.
  always_comb begin
    next_st        = st;
    next_st.tck_s  = {st.tck_s[1:0], tck_i};
    next_st.tms_s  = {st.tms_s[0], tms_i};
    next_st.tdi_s  = {st.tdi_s[0], tdi_i};
    next_st.pin_s1 = {ctrl_pin_i, a_pin_i, b_pin_i};
    next_st.pin_s2 = st.pin_s1;
    if (tck_rise) begin
      next_st.tap = tap_next(st.tap, tms);
      case (st.tap)
        TAP_CAP_IR: begin
          next_st.ir_sh = IR_CAPTURE_VAL;
        end
        TAP_SHIFT_IR: begin
          next_st.ir_sh = {tdi, st.ir_sh[7:1]};
        end
        TAP_CAP_DR: begin
          next_st.bypass = 1'b0;
          if (st.ir == IR_CELL_SELF) begin
            next_st.boundary_register = ~st.shadow;
          end else if (sel_bsr && !is_read) begin
            next_st.boundary_register = {pins[21:8], core_a_i, pins[7:0], core_b_i};
          end
        end
        TAP_SHIFT_DR: begin
          next_st.bypass = tdi;
          if (sel_bsr) begin
            next_st.boundary_register = {tdi, st.boundary_register[37:1]};
          end else if (sel_bcr) begin
            next_st.boundary_control = {tdi, st.boundary_control[10:1]};
          end
        end
        TAP_IDLE: begin
          if (run_step) begin
            if (a_to_b) begin
              next_st.boundary_register[BSR_AI_LO +: 8] = new_in;
              next_st.boundary_register[BSR_BO_LO +: 8] = new_out;
            end else begin
              next_st.boundary_register[BSR_BI_LO +: 8] = new_in;
              next_st.boundary_register[BSR_AO_LO +: 8] = new_out;
            end
          end
        end
        default: begin
          next_st.bypass = st.bypass;
        end
      endcase
    end
    if (tck_fall) begin
      next_st.tdo_oe = st.tap == TAP_SHIFT_IR || st.tap == TAP_SHIFT_DR;
      next_st.tdo    = st.tap == TAP_SHIFT_IR ? st.ir_sh[0] :
                       sel_bsr ? st.boundary_register[0] : sel_bcr ? st.boundary_control[0] : st.bypass;
      if (st.tap == TAP_UPD_IR) begin
        next_st.ir = st.ir_sh;
      end
      if (st.tap == TAP_UPD_DR && sel_bsr) begin
        next_st.shadow = st.boundary_register;
      end
      // Shadow latches follow the stepped cells on the falling edge, output latches only outside signature.
      if (st.tap == TAP_IDLE && one_dir && (st.ir == IR_RUN_TEST || st.ir == IR_TOGGLE_OUT)) begin
        if (st.ir == IR_RUN_TEST) begin
          next_st.shadow[BSR_AI_LO +: 8] = st.boundary_register[BSR_AI_LO +: 8];
          next_st.shadow[BSR_BI_LO +: 8] = st.boundary_register[BSR_BI_LO +: 8];
        end
        if (st.ir == IR_TOGGLE_OUT || st.boundary_control[1:0] != OP_SIGNATURE) begin
          next_st.shadow[BSR_BO_LO +: 8] = st.boundary_register[BSR_BO_LO +: 8];
          next_st.shadow[BSR_AO_LO +: 8] = st.boundary_register[BSR_AO_LO +: 8];
        end
      end
    end
    if (st.tap == TAP_RESET) begin
      next_st.ir  = IR_RESET_VAL;
      next_st.boundary_control = BCR_RESET;
    end
    // Pin and core drive: cells in test mode, normal path otherwise.
    if (test_mode) begin
      next_st.a_out   = st.shadow[BSR_AO_LO +: 8];
      next_st.b_out   = st.shadow[BSR_BO_LO +: 8];
      next_st.a_oe    = ~st.shadow[BSR_B_TO_A_OUTPUT_ENABLE_N];
      next_st.b_oe    = ~st.shadow[BSR_A_TO_B_OUTPUT_ENABLE_N];
      next_st.to_core = {st.shadow[BSR_CTRL_LO +: 6], st.shadow[BSR_AI_LO +: 8], st.shadow[BSR_BI_LO +: 8]};
    end else begin
      next_st.a_out   = core_a_i;
      next_st.b_out   = core_b_i;
      next_st.a_oe    = ~pins[20] && st.ir != IR_HIGHZ;
      next_st.b_oe    = ~pins[21] && st.ir != IR_HIGHZ;
      next_st.to_core = pins;
    end
  end

  // Registers the whole state.
  always_ff @(posedge clock_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st        <= '0;
      st.tap    <= TAP_RESET;
      st.ir     <= IR_RESET_VAL;
      st.ir_sh  <= IR_CAPTURE_VAL;
      st.boundary_control    <= BCR_RESET;
      st.shadow <= 38'h3000000000;
    end else begin
      st <= next_st;
    end
  end

  assign tdo_o     = st.tdo;
  assign tdo_oe_o  = st.tdo_oe;
  assign a_out_o   = st.a_out;
  assign a_oe_o    = st.a_oe;
  assign b_out_o   = st.b_out;
  assign b_oe_o    = st.b_oe;
  assign to_core_o = st.to_core;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_cap_dr;
    tck_rise && st.tap == TAP_CAP_DR;
  endsequence

  sequence s_sig_masked;
    run_step && st.ir == IR_RUN_TEST && st.boundary_control[1:0] == OP_SIGNATURE && a_to_b && st.boundary_control[10:3] == 8'hff;
  endsequence

  sequence s_toggle_ab;
    run_step && st.ir == IR_TOGGLE_OUT && a_to_b;
  endsequence

  // A sample/toggle step in the A-to-B direction.
  sequence s_sample_ab;
    run_step && st.ir == IR_RUN_TEST && st.boundary_control[1:0] == OP_SAMPLE_TOG && a_to_b;
  endsequence

  // A pattern step from an all-zero seed in the A-to-B direction.
  sequence s_zero_pattern;
    run_step && st.ir == IR_RUN_TEST && st.boundary_control[1:0] == OP_PATTERN && a_to_b &&
    {st.boundary_register[31:24], st.boundary_register[7:0]} == 16'h0000;
  endsequence

  // A falling test clock in idle while a signature runs.
  sequence s_sig_fall;
    tck_fall && st.tap == TAP_IDLE && st.ir == IR_RUN_TEST && st.boundary_control[1:0] == OP_SIGNATURE;
  endsequence

  a_bypass_zero: assert property (s_cap_dr ##0 (!sel_bsr && !sel_bcr) |=> !st.bypass)
    else $error("bypass did not capture zero");
  a_bcr_hold: assert property (s_cap_dr ##0 sel_bcr |=> $stable(st.boundary_control))
    else $error("control register changed at capture");
  a_read_hold: assert property (s_cap_dr ##0 is_read |=> $stable(st.boundary_register))
    else $error("boundary read altered cells");
  a_self_inverse: assert property (s_cap_dr ##0 st.ir == IR_CELL_SELF |=> st.boundary_register == ~$past(st.shadow))
    else $error("self test did not invert");
  a_highz_float: assert property (st.ir == IR_HIGHZ |=> !a_oe_o && !b_oe_o)
    else $error("pins driven under high impedance");
  a_bcr_reset: assert property (st.tap == TAP_RESET |=> st.boundary_control == BCR_RESET)
    else $error("control register not reset");
  a_clamp_drive: assert property (st.ir == IR_CLAMP |=> b_out_o == $past(st.shadow[7:0]))
    else $error("clamp pins not from cells");
  a_two_dir_idle: assert property (tck_rise && st.tap == TAP_IDLE && st.ir == IR_RUN_TEST && !one_dir
                                   |=> $stable(st.boundary_register))
    else $error("run test acted with two directions");
  a_mask_ignore: assert property (s_sig_masked |=> {st.boundary_register[31:24], st.boundary_register[7:0]} ==
                                  lfsr16($past({st.boundary_register[31:24], st.boundary_register[7:0]}), TAP16_AB))
    else $error("masked input reached signature");
  a_toggle_out: assert property (s_toggle_ab |=> st.boundary_register[7:0] == ~$past(st.boundary_register[7:0])
                                 ##0 $stable(st.boundary_register[31:24]))
    else $error("toggle outputs misbehaved");
  a_sample_capture: assert property (s_sample_ab |=> st.boundary_register[31:24] == $past(pins[15:8])
                                     ##0 st.boundary_register[7:0] == ~$past(st.boundary_register[7:0]))
    else $error("sample step did not capture pins");
  a_zero_stuck: assert property (s_zero_pattern |=> {st.boundary_register[31:24], st.boundary_register[7:0]} == 16'h0000)
    else $error("zero seed produced a pattern");
  a_sig_out_hold: assert property (s_sig_fall |=> $stable(st.shadow[BSR_BO_LO +: 8])
                                   ##0 $stable(st.shadow[BSR_AO_LO +: 8]))
    else $error("output latches moved during signature");
endmodule : bst_scan_ops
`default_nettype wire

// ---- sim/bst_jtag_host.sv ----
// Behavioural scan controller that drives the four-wire test port.
`default_nettype none
module bst_jtag_host (
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [63:0] got;
  ////////////////////////////////////////////////////////////////////////
  // Test clock rests low between frames; data in rests high like a pulled-up line.
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
    got   = '0;
  end
  // One test clock: change while low, sample data out late in the high phase.
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    tms_o = tms;
    tdi_o = tdi;
    #200 tck_o = 1'b1;
    #199 tdo = tdo_i;
    #1 tck_o = 1'b0;
  endtask : step
  // Five clocks with select high reach reset; one more with it low parks in idle.
  task automatic tlr();
    logic d;
    repeat (5) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask : tlr
  // Stay in idle for n test clocks.
  task automatic idle(input int n);
    logic d;
    repeat (n) step(1'b0, 1'b1, d);
  endtask : idle
  // Scan n bits, low bit first, through the instruction or data path, back to idle.
  task automatic scan(input logic ir, input int n, input logic [63:0] din);
    logic d;
    step(1'b1, 1'b1, d);
    if (ir) step(1'b1, 1'b1, d);
    repeat (2) step(1'b0, 1'b1, d);
    for (int i = 0; i < n; i++) step(i == n - 1, din[i], got[i]);
    step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask : scan
endmodule : bst_jtag_host
`default_nettype wire

// ---- sim/testbench.sv ----
// Self-checking bench for the boundary-scan test operations block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import bst_pkg::*;
  localparam logic [37:0] SEED = {2'b01, 4'hf, 32'h1122_33c4};
  // Rows: instruction, pin check wanted, expected B enable, expected A enable.
  localparam logic [10:0] ROWS [10] = '{{8'h81, 3'h6}, {8'h84, 3'h6}, {8'h05, 3'h6}, {8'h88, 3'h6},
    {8'hff, 3'h6}, {8'h10, 3'h6}, {IR_HIGHZ, 3'h4}, {IR_CLAMP, 3'h4}, {IR_RUN_TEST, 3'h0}, {IR_TOGGLE_OUT, 3'h0}};
  logic        clock, arst_n, tck, tms, tdi, tdo, tdo_oe, a_oe, b_oe;
  logic [5:0]  ctrl;
  logic [7:0]  a_pin, b_pin, core_a, core_b, a_out, b_out;
  logic [15:0] bo;
  logic [21:0] to_core;
  logic [37:0] r1, r2;
  int          mismatches, comparisons;

  bst_scan_ops dut (.clock_i(clock), .arst_n_i(arst_n), .tck_i(tck), .tms_i(tms), .tdi_i(tdi),
    .tdo_o(tdo), .tdo_oe_o(tdo_oe), .ctrl_pin_i(ctrl), .a_pin_i(a_pin), .b_pin_i(b_pin),
    .core_a_i(core_a), .core_b_i(core_b), .a_out_o(a_out), .a_oe_o(a_oe), .b_out_o(b_out),
    .b_oe_o(b_oe), .to_core_o(to_core));
  bst_jtag_host host (.tck_o(tck), .tms_o(tms), .tdi_o(tdi), .tdo_i(tdo));
  ////////////////////////////////////////////////////////////////////////
  // System clock at 20 MHz.
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  // Compare scan data and pin values, counting every comparison.
  task automatic chk_scan(input logic [37:0] g, input logic [37:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk_scan
  task automatic chk_pin(input logic [21:0] g, input logic [21:0] e);
    chk_scan({16'h0, g}, {16'h0, e});
  endtask : chk_pin
  task automatic test_done();
    if (mismatches == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Let synchronisers and output registers catch up with the last test clock.
  task automatic settle();
    repeat (8) @(posedge clock);
    @(negedge clock);
  endtask : settle
  task automatic ir(input logic [7:0] code);
    host.scan(1'b1, 8, {56'h0, code});
    chk_scan({30'h0, host.got[7:0]}, 38'h81);
  endtask : ir
  task automatic dr(input int n, input logic [37:0] d, input logic [37:0] e);
    host.scan(1'b0, n, {26'h0, d});
    chk_scan(host.got[37:0] & ((38'h1 << n) - 38'h1), e);
  endtask : dr
  // Load the control register and a seed, run one idle clock, then read the cells back after the next scan's first idle clock steps them again.
  task automatic run(input logic [10:0] ctl, input logic [37:0] seed, input logic [7:0] a,
                     output logic [37:0] r, output logic [15:0] o);
    ir(IR_CTRL_NORMAL);
    host.scan(1'b0, 11, {53'h0, ctl});
    ir(IR_SAMPLE);
    host.scan(1'b0, 38, {26'h0, seed});
    @(negedge clock) a_pin = a;
    ir(IR_RUN_TEST);
    host.idle(1);
    settle();
    o = {to_core[15:8], b_out};
    ir(IR_READ_NORMAL);
    host.scan(1'b0, 38, {26'h0, seed});
    r = host.got[37:0];
  endtask : run
  // Watchdog: the sequence needs about 1 ms of test clocks, so 4 ms means a hang.
  initial begin
    #4ms;
    mismatches++;
    test_done();
  end
  ////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, table of bypass-type instructions, then hand-written cases.
  initial begin
    arst_n = 1'b0;
    ctrl   = 6'h1f;
    a_pin  = 8'h5a;
    b_pin  = 8'h3c;
    core_a = 8'h96;
    core_b = 8'h69;
    repeat (3) @(negedge clock);
    chk_pin({tdo_oe, a_oe, b_oe, b_out, a_out}, '0);
    arst_n = 1'b1;
    repeat (4) @(negedge clock);
    host.tlr();
    foreach (ROWS[i]) begin
      ir(ROWS[i][10:3]);
      dr(8, 38'ha5, 38'h4a);
      settle();
      if (ROWS[i][2]) chk_pin({b_oe, a_oe}, ROWS[i][1:0]);
    end
    ir(IR_CTRL_NORMAL);
    dr(11, 11'h7fa, 11'h002);
    ir(IR_CTRL_TEST);
    dr(11, 11'h7fa, 11'h7fa);
    ir(IR_SAMPLE);
    dr(38, SEED, {ctrl, a_pin, core_a, b_pin, core_b});
    chk_pin({b_oe, b_out}, {1'b1, core_b});
    ir(IR_READ_NORMAL);
    dr(38, SEED, SEED);
    ir(IR_READ_TEST);
    dr(38, SEED, SEED);
    ir(IR_CELL_SELF);
    dr(38, SEED, ~SEED);
    ir(IR_CLAMP);
    settle();
    chk_pin({b_oe, a_oe, b_out}, {2'b10, 8'hc4});
    chk_pin(to_core, {6'h1f, 8'h11, 8'h33});
    chk_pin({tdo_oe, a_out}, {1'b0, 8'h22});
    ir(IR_TOGGLE_OUT);
    host.idle(3);
    settle();
    chk_pin({b_out, to_core[15:8]}, {8'h3b, 8'h11});
    run(11'h004, SEED, 8'h6c, r1, bo);
    chk_pin(bo, {8'h6c, 8'h3b});
    run(11'h004, {2'b10, SEED[35:0]}, 8'h6c, r2, bo);
    chk_scan(r2, {2'b10, 4'hf, 8'h11, 8'h22, 8'h3c, 8'hc4});
    chk_pin(bo, {8'h11, 8'hc4});
    run(11'h00a, SEED, 8'h5a, r1, bo);
    chk_pin(bo[7:0], 8'hc4);
    run(11'h00a, SEED, 8'h5b, r2, bo);
    chk_scan(r2, r1);
    run(11'h00a, SEED, 8'hda, r2, bo);
    chk_scan(r2 !== r1, 1'b1);
    run(11'h402, SEED, 8'h5a, r1, bo);
    run(11'h402, SEED, 8'hda, r2, bo);
    chk_scan(r2, r1);
    run(11'h7fa, SEED, 8'h5a, r1, bo);
    run(11'h7fa, SEED, 8'ha5, r2, bo);
    chk_scan(r2, r1);
    run(11'h001, {6'h1f, 32'h0}, 8'h5a, r2, bo);
    chk_scan({6'h0, r2[31:0]}, '0);
    chk_pin(bo[7:0], 8'h00);
    run(11'h001, SEED, 8'h5a, r2, bo);
    chk_scan(bo[7:0] !== 8'hc4, 1'b1);
    run(11'h004, {2'b00, SEED[35:0]}, 8'h6c, r2, bo);
    chk_scan(r2, {2'b00, SEED[35:0]});
    run(11'h003, SEED, 8'h5a, r2, bo);
    chk_scan(bo[7:0] !== 8'hc4, 1'b1);
    run(11'h007, SEED, 8'h5a, r2, bo);
    chk_pin(bo[7:0], 8'hc5);
    chk_pin(r2[7:0], 8'hc6);
    host.tlr();
    ir(IR_CTRL_NORMAL);
    dr(11, 11'h000, 11'h002);
    test_done();
  end
endmodule : testbench
`default_nettype wire
